// ### logic/bss_boot_standby.sv
`timescale 1ns/1ps
`include "bss_cfg.svh"

//////////////////////////////////////////////////////////////////////
// Operation
// RL1 - sample four straps right after reset release
// RL2 - after boot, fetch from reset entry
// RL3 - low three straps encode boot mode
// RL4 - system straps no-boot on standby return
// RL5 - memory boot copies X, Y, XY, external
// RL6 - host boot: parameters then code via host
// RL7 - serial boot: parameters then code serially
// RL8 - reboot entries one to four: memory
// RL9 - entry five: host reboot with parameters
// RL10 - entry six: serial reboot with parameters
// RL11 - software loads steps and destination page
// RL12 - software loads source pointers and page
// RL13 - host/serial destination offset by 0x8000
// RL14 - serial reboot status value 0x0EC0
// RL15 - halt stops all but clock, PLL
// RL16 - halt leaves on interrupt, 10-20 clocks
// RL17 - software picks external clock first
// RL18 - halt runs divided system and output clock
// RL19 - stop masks internal system clock
// RL20 - stop with PLL off halts clock circuit
// RL21 - stop leaves on reset or release pin
// RL22 - fourth strap selects PLL lock range
// RL23 - stop exit needs no PLL lock wait
// RL24 - PLL off at reset, started by boot
// RL25 - strap 111 falls back to no boot
module bss_boot_standby #(
   parameter int unsigned PLL_LOCK_CYCLES = `BSS_PLL_LOCK_US * `BSS_CLK_MHZ
) (
   input  wire logic        i_clock,
   input  wire logic        i_reset_n,
   input  wire logic        i_boot_strap_bit0,
   input  wire logic        i_boot_strap_bit1,
   input  wire logic        i_boot_strap_bit2,
   input  wire logic        i_lock_range_strap,
   input  wire logic        i_sleep_release_pin,
   input  wire logic        i_halt_instr,
   input  wire logic        i_stop_instr,
   input  wire logic        i_irq,
   input  wire logic        i_copy_done,
   input  wire logic [3:0]  i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [15:0] o_reg_rdata,
   output logic      [2:0]  o_boot_mode,
   output logic             o_lock_range,
   output logic             o_pll_enable,
   output logic             o_pll_select,
   output logic             o_clkgen_run,
   output logic             o_sys_clk_en,
   output logic             o_sys_tick,
   output logic             o_clock_output_pin,
   output logic             o_core_run,
   output logic             o_fetch_start,
   output logic      [15:0] o_fetch_addr,
   output logic             o_reboot_done,
   output logic             o_copy_req,
   output logic      [2:0]  o_copy_mode,
   output logic      [15:0] o_step_count_param,
   output logic      [15:0] o_source_page_param,
   output logic      [15:0] o_dest_page_param,
   output logic      [15:0] o_dest_addr_pointer_x,
   output logic      [15:0] o_dest_addr_pointer_y,
   output logic      [15:0] o_src_addr_pointer_x,
   output logic      [15:0] o_src_addr_pointer_y
);
   bss_pkg::bss_state_t st_q;          // sequencer state
   bss_pkg::bss_boot_t  mode_q;        // boot mode from straps
   bss_pkg::bss_boot_t  copy_mode_q;   // mode handed to copy engines
   logic [3:0]  strap_s1_q;            // strap sync, first stage
   logic [3:0]  strap_s2_q;            // strap sync, second stage
   logic        rel_s1_q;              // release pin sync, first stage
   logic        rel_s2_q;              // release pin sync, second stage
   logic        rel_s3_q;              // for the edge
   logic [1:0]  strap_cnt_q;           // lets the sync chain fill
   logic [15:0] lock_cnt_q;            // PLL lock time count
   logic [4:0]  wake_cnt_q;            // halt release delay
   logic [15:0] ctl_q;                 // clock control register
   logic [15:0] params_q [0:6];        // reboot parameter words
   logic        lock_range_q;
   logic        copy_req_q;
   logic        fetch_q;
   logic        core_run_q;
   logic        reboot_q;              // copy started by software
   logic        reboot_done_q;
   logic [15:0] fetch_addr_q;
   logic [15:0] rdata_q;
   logic        tick_q;
   logic        pin_q;
   logic        strap_done;
   logic        pll_locked;
   logic        rel_rise;
   logic        boot_pll_start;
   logic        boot_pll_sel;
   logic        reboot_wr;
   bss_pkg::bss_boot_t strap_mode;
   bss_pkg::bss_boot_t entry_mode;

   bss_clk_if clk ();

   // maps a 3-bit code to a boot mode; the unused code means no boot
   function automatic bss_pkg::bss_boot_t bss_mode_of(input logic [2:0] code);
      bss_mode_of = bss_pkg::bss_boot_t'(code);
      if (code == 3'h7) begin
         bss_mode_of = bss_pkg::BSS_NO_BOOT; // RL25
      end
   endfunction

   //////////////////////////////////////////////////////////////////////
   // synchronisers: straps and release pin come from outside the clock
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         strap_s1_q <= 4'h0;
         strap_s2_q <= 4'h0;
         rel_s1_q   <= 1'b0;
         rel_s2_q   <= 1'b0;
         rel_s3_q   <= 1'b0;
      end else begin
         strap_s1_q <= {i_lock_range_strap, i_boot_strap_bit2,
                        i_boot_strap_bit1, i_boot_strap_bit0};
         strap_s2_q <= strap_s1_q;
         rel_s1_q   <= i_sleep_release_pin;
         rel_s2_q   <= rel_s1_q;
         rel_s3_q   <= rel_s2_q;
      end
   end

   // the straps are read once the chain holds post-reset samples
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         strap_cnt_q <= 2'h0;
      end else if (strap_cnt_q != 2'h3) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   assign strap_done = st_q == bss_pkg::ST_STRAP && strap_cnt_q == 2'h3;
   assign strap_mode = bss_mode_of(strap_s2_q[2:0]); // RL3
   assign entry_mode = bss_mode_of(i_reg_wdata[2:0]);
   assign rel_rise   = rel_s2_q && !rel_s3_q;
   assign pll_locked = lock_cnt_q == PLL_LOCK_CYCLES[15:0];
   // no-boot and external boot stay on the input clock
   assign boot_pll_start = strap_done && strap_mode != bss_pkg::BSS_NO_BOOT
                           && strap_mode != bss_pkg::BSS_EXT_MEM; // RL24
   assign boot_pll_sel = st_q == bss_pkg::ST_PLL_WAIT && pll_locked;
   // reboot accepted only while running and only for entries one to six
   assign reboot_wr = i_reg_wr && i_reg_addr == `BSS_ADDR_REBOOT
                      && st_q == bss_pkg::ST_RUN
                      && entry_mode != bss_pkg::BSS_NO_BOOT; // RL8

   //////////////////////////////////////////////////////////////////////
   // clock control register; boot turns the PLL on and selects it
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         ctl_q <= `BSS_CLKCTL_RST; // RL24
      end else begin
         if (i_reg_wr && i_reg_addr == `BSS_ADDR_CLKCTL) begin
            ctl_q <= i_reg_wdata;
         end
         if (boot_pll_start) begin
            ctl_q[`BSS_CLK_PLL_ON] <= 1'b1; // RL24
         end
         if (boot_pll_sel) begin
            ctl_q[`BSS_CLK_SRC_PLL] <= 1'b1;
         end
      end
   end

   // lock time counts only while the PLL is on; switching it off
   // restarts the count, which is why stop keeps it running
   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !ctl_q[`BSS_CLK_PLL_ON]) begin
         lock_cnt_q <= 16'h0000;
      end else if (!pll_locked) begin
         lock_cnt_q <= lock_cnt_q + 16'h0001;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // reboot parameter words, forwarded to the copy engines
   generate
      for (genvar g = 0; g < 7; g++) begin : g_param
         always_ff @(posedge i_clock) begin
            if (!i_reset_n) begin
               params_q[g] <= 16'h0000;
            end else if (i_reg_wr && i_reg_addr == 4'(g + 2)) begin
               params_q[g] <= i_reg_wdata; // RL9
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////
   // boot and standby sequencer
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         st_q          <= bss_pkg::ST_STRAP;
         mode_q        <= bss_pkg::BSS_NO_BOOT;
         copy_mode_q   <= bss_pkg::BSS_NO_BOOT;
         lock_range_q  <= 1'b0;
         copy_req_q    <= 1'b0;
         fetch_q       <= 1'b0;
         core_run_q    <= 1'b0;
         reboot_q      <= 1'b0;
         reboot_done_q <= 1'b0;
         fetch_addr_q  <= 16'h0000;
         wake_cnt_q    <= 5'h00;
      end else begin
         fetch_q       <= 1'b0;
         reboot_done_q <= 1'b0;
         case (st_q)
            bss_pkg::ST_STRAP: begin
               if (strap_done) begin
                  mode_q       <= strap_mode; // RL1
                  lock_range_q <= strap_s2_q[3]; // RL22
                  copy_mode_q  <= strap_mode;
                  if (strap_mode == bss_pkg::BSS_NO_BOOT) begin
                     // nothing to load: straight to the reset entry
                     st_q         <= bss_pkg::ST_RUN;
                     fetch_q      <= 1'b1;
                     core_run_q   <= 1'b1;
                     fetch_addr_q <= `BSS_RESET_ENTRY; // RL2
                  end else if (strap_mode == bss_pkg::BSS_EXT_MEM) begin
                     st_q       <= bss_pkg::ST_COPY;
                     copy_req_q <= 1'b1; // RL5
                  end else begin
                     st_q <= bss_pkg::ST_PLL_WAIT; // RL24
                  end
               end
            end
            bss_pkg::ST_PLL_WAIT: begin
               // X, Y and XY memory, host and serial loads run on the PLL output
               if (pll_locked) begin
                  st_q       <= bss_pkg::ST_COPY;
                  copy_req_q <= 1'b1; // RL6
               end
            end
            bss_pkg::ST_COPY: begin
               // the engine picked by copy mode moves the code
               if (i_copy_done) begin
                  copy_req_q <= 1'b0;
                  st_q       <= bss_pkg::ST_RUN;
                  core_run_q <= 1'b1;
                  reboot_q   <= 1'b0;
                  if (reboot_q) begin
                     reboot_done_q <= 1'b1; // RL10
                  end else begin
                     fetch_q      <= 1'b1;
                     fetch_addr_q <= `BSS_RESET_ENTRY; // RL2
                  end
               end
            end
            bss_pkg::ST_RUN: begin
               if (reboot_wr) begin
                  // entry number equals copy mode code
                  st_q        <= bss_pkg::ST_COPY;
                  copy_mode_q <= entry_mode; // RL7
                  copy_req_q  <= 1'b1;
                  reboot_q    <= 1'b1;
                  core_run_q  <= 1'b0;
               end else if (i_stop_instr) begin
                  st_q       <= bss_pkg::ST_STOP; // RL19
                  core_run_q <= 1'b0;
               end else if (i_halt_instr) begin
                  st_q       <= bss_pkg::ST_HALT; // RL15
                  core_run_q <= 1'b0;
               end
            end
            bss_pkg::ST_HALT: begin
               // state and memory are untouched; only the core waits
               if (i_irq) begin
                  st_q       <= bss_pkg::ST_WAKE;
                  wake_cnt_q <= 5'h01;
               end
            end
            bss_pkg::ST_WAKE: begin
               if (wake_cnt_q == 5'(`BSS_HALT_WAKE_MIN - 1)) begin
                  st_q       <= bss_pkg::ST_RUN; // RL16
                  core_run_q <= 1'b1;
               end else begin
                  wake_cnt_q <= wake_cnt_q + 5'h01;
               end
            end
            bss_pkg::ST_STOP: begin
               // the PLL was never stopped by hardware, so no lock wait
               if (rel_rise) begin
                  st_q       <= bss_pkg::ST_RUN; // RL21
                  core_run_q <= 1'b1; // RL23
               end
            end
            default: begin
               st_q <= bss_pkg::ST_STRAP;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // divider control: halt forces divided rate, stop masks the clock
   assign clk.ratio   = ctl_q[`BSS_CLK_RATIO_HI:`BSS_CLK_RATIO_LO];
   assign clk.div_sel = ctl_q[`BSS_CLK_DIV_SEL]
                        || st_q == bss_pkg::ST_HALT; // RL18
   assign clk.gate    = st_q == bss_pkg::ST_STOP; // RL19
   assign clk.out_en  = ctl_q[`BSS_CLK_OUT_EN];

   bss_clk_div u_div (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .clk       (clk.gen)
   );

   // divider outputs retimed so every port leaves a local flop
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         tick_q <= 1'b0;
         pin_q  <= 1'b0;
      end else begin
         tick_q <= clk.tick;
         pin_q  <= clk.pin;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // register read port: data stand in the cycle after the strobe
   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !i_reg_rd) begin
         rdata_q <= 16'h0000;
      end else begin
         case (i_reg_addr)
            `BSS_ADDR_CLKCTL: rdata_q <= ctl_q;
            `BSS_ADDR_STATUS: rdata_q <= {7'h00, copy_req_q, pll_locked,
                                          lock_range_q, st_q, mode_q};
            `BSS_ADDR_REBOOT: rdata_q <= {13'h0000, copy_mode_q};
            default: begin
               if (i_reg_addr >= `BSS_ADDR_STEPS
                   && i_reg_addr <= `BSS_ADDR_SRC_Y) begin
                  rdata_q <= params_q[3'(i_reg_addr - `BSS_ADDR_STEPS)];
               end else begin
                  rdata_q <= 16'h0000; // unmapped reads as zero
               end
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // outputs
   assign o_reg_rdata           = rdata_q;
   assign o_boot_mode           = mode_q;
   assign o_lock_range          = lock_range_q;
   assign o_pll_enable          = ctl_q[`BSS_CLK_PLL_ON];
   assign o_pll_select          = ctl_q[`BSS_CLK_SRC_PLL];
   assign o_sys_tick            = tick_q;
   assign o_clock_output_pin    = pin_q;
   assign o_core_run            = core_run_q;
   assign o_fetch_start         = fetch_q;
   assign o_fetch_addr          = fetch_addr_q;
   assign o_reboot_done         = reboot_done_q;
   assign o_copy_req            = copy_req_q;
   assign o_copy_mode           = copy_mode_q;
   assign o_step_count_param    = params_q[0];
   assign o_source_page_param   = params_q[1];
   assign o_dest_page_param     = params_q[2];
   assign o_dest_addr_pointer_x = params_q[3];
   assign o_dest_addr_pointer_y = params_q[4];
   assign o_src_addr_pointer_x  = params_q[5];
   assign o_src_addr_pointer_y  = params_q[6];

   // system enable and clock circuit state kept in flops
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_sys_clk_en <= 1'b1;
         o_clkgen_run <= 1'b1;
      end else begin
         o_sys_clk_en <= st_q != bss_pkg::ST_STOP; // RL19
         o_clkgen_run <= !(st_q == bss_pkg::ST_STOP
                           && !ctl_q[`BSS_CLK_PLL_ON]); // RL20
      end
   end

   //////////////////////////////////////////////////////////////////////
   // checks
   AST_STRAP_LATCH: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      strap_done |=> o_boot_mode == bss_mode_of($past(strap_s2_q[2:0])))
      else $error("boot mode not taken from straps"); // RL1
   AST_FETCH_ENTRY: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      o_fetch_start |-> o_fetch_addr == `BSS_RESET_ENTRY && o_core_run)
      else $error("fetch not at reset entry"); // RL2
   AST_RESERVED: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      strap_done && strap_s2_q[2:0] == 3'h7 |=> o_fetch_start && !o_copy_req)
      else $error("reserved strap did not fall back"); // RL25
   AST_LOCK_RANGE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      strap_done |=> o_lock_range == $past(strap_s2_q[3]))
      else $error("lock range strap not taken"); // RL22
   AST_NO_PLL: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      strap_done && (strap_s2_q[2:0] == 3'h0 || strap_s2_q[2:0] == 3'h4)
      |=> !o_pll_enable)
      else $error("PLL started for input-clock boot"); // RL24
   AST_COPY_HOLD: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      o_copy_req && !i_copy_done |=> o_copy_req && $stable(o_copy_mode))
      else $error("copy request dropped early"); // RL5
   AST_HALT_DIV: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      st_q == bss_pkg::ST_HALT |-> clk.div_sel && !clk.gate && !o_core_run)
      else $error("halt clocking wrong"); // RL18
   AST_HALT_WAKE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      st_q == bss_pkg::ST_HALT && i_irq |-> ##1 !o_core_run[*8] ##[1:12] o_core_run)
      else $error("halt release not in 10 to 20 clocks"); // RL16
   AST_STOP_GATE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      st_q == bss_pkg::ST_STOP |=> !o_sys_clk_en)
      else $error("system clock not masked in stop"); // RL19
   AST_STOP_PLL: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      st_q == bss_pkg::ST_STOP && !o_pll_enable |=> !o_clkgen_run)
      else $error("clock circuit runs in stop with PLL off"); // RL20
   AST_STOP_EXIT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      st_q == bss_pkg::ST_STOP && rel_rise |=> o_core_run && !o_fetch_start)
      else $error("stop release failed"); // RL21
endmodule // bss_boot_standby

// ### logic/bss_cfg.svh
`ifndef BSS_CFG_SVH
`define BSS_CFG_SVH
// instruction fetch address taken once a boot has finished
`define BSS_RESET_ENTRY     16'h0200
// register offsets on the plain register port (16-bit words)
`define BSS_ADDR_CLKCTL     4'h0
`define BSS_ADDR_STATUS     4'h1
`define BSS_ADDR_STEPS      4'h2
`define BSS_ADDR_SRC_PAGE   4'h3
`define BSS_ADDR_DST_PAGE   4'h4
`define BSS_ADDR_DST_X      4'h5
`define BSS_ADDR_DST_Y      4'h6
`define BSS_ADDR_SRC_X      4'h7
`define BSS_ADDR_SRC_Y      4'h8
`define BSS_ADDR_REBOOT     4'h9
// clock control register fields
`define BSS_CLK_PLL_ON      0
`define BSS_CLK_SRC_PLL     1
`define BSS_CLK_DIV_SEL     2
`define BSS_CLK_OUT_EN      3
`define BSS_CLK_RATIO_LO    4
`define BSS_CLK_RATIO_HI    6
`define BSS_CLKCTL_RST      16'h0008
// timing
`define BSS_CLK_MHZ         40
`define BSS_PLL_LOCK_US     300
`define BSS_HALT_WAKE_MIN   10
`define BSS_HALT_WAKE_MAX   20
`endif

// ### logic/bss_pkg.sv
package bss_pkg;
   // boot modes, listed in strap order 000..111
   typedef enum logic [2:0] {
      BSS_NO_BOOT, BSS_X_MEM, BSS_Y_MEM, BSS_XY_MEM,
      BSS_EXT_MEM, BSS_HOST, BSS_SERIAL, BSS_RESERVED
   } bss_boot_t;
   // sequencer states
   typedef enum logic [2:0] {
      ST_STRAP, ST_PLL_WAIT, ST_COPY, ST_RUN, ST_HALT, ST_WAKE, ST_STOP
   } bss_state_t;
endpackage

// ### logic/bss_clk_if.sv
`timescale 1ns/1ps
// control of the system clock divider
interface bss_clk_if;
   logic [2:0] ratio;    // divide by ratio+1
   logic       div_sel;  // divided rate selected
   logic       gate;     // system clock masked
   logic       out_en;   // clock output pin enabled
   logic       tick;     // system clock enable pulse
   logic       pin;      // clock output pin level
   modport ctl (output ratio, div_sel, gate, out_en, input tick, pin);
   modport gen (input ratio, div_sel, gate, out_en, output tick, pin);
endinterface // bss_clk_if

// ### logic/bss_clk_div.sv
`timescale 1ns/1ps
module bss_clk_div (
   input  wire logic i_clock,
   input  wire logic i_reset_n,
   bss_clk_if.gen    clk
);
   logic [2:0] cnt_q;   // position within divided period
   logic       tick_q;  // enable pulse
   logic       pin_q;   // pin level

   ////////////////////////////////////////////////////////////////////
   // period counter, held at zero while masked
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         cnt_q <= 3'h0;
      end else if (clk.gate || !clk.div_sel || cnt_q == clk.ratio) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   // one pulse per period; none at all while masked
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= !clk.gate && (!clk.div_sel || cnt_q == clk.ratio);
      end
   end

   // divided: high for one cycle per period, not 50 % duty.
   // undivided: a flop cannot copy the clock, so it toggles instead
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         pin_q <= 1'b0;
      end else if (clk.gate || !clk.out_en) begin
         pin_q <= 1'b0;
      end else if (clk.div_sel) begin
         pin_q <= cnt_q == clk.ratio;
      end else begin
         pin_q <= !pin_q;
      end
   end

   assign clk.tick = tick_q;
   assign clk.pin  = pin_q;
endmodule // bss_clk_div

// ### tb/bss_copy_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////
// copy engine stand-in: ends each copy request after a short or long delay
module bss_copy_partner (
   input  wire logic       i_clock,
   input  wire logic       i_copy_req,
   input  wire logic [2:0] i_copy_mode,
   input  wire logic       i_slow,
   output logic            o_copy_done = 1'b0,
   output logic [2:0]      o_seen_mode = 3'h0
);
   int cnt = 0; // cycles spent on the current request
   // one done pulse per request; done high blocks a second answer to a held request
   always @(posedge i_clock) begin
      o_copy_done <= 1'b0;
      if (i_copy_req && !o_copy_done) begin
         cnt <= cnt + 1;
         if (cnt == (i_slow ? 9 : 1)) begin
            o_copy_done <= 1'b1;
            o_seen_mode <= i_copy_mode;
            cnt         <= 0;
         end
      end else cnt <= 0;
   end
endmodule // bss_copy_partner

// ### tb/bss_boot_standby_tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////
module bss_boot_standby_tb_top;
   logic i_clock = 1'b0, i_reset_n = 1'b0, i_sleep_release_pin = 1'b0, i_halt_instr = 1'b0;
   logic i_stop_instr = 1'b0, i_irq = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, slow = 1'b0;
   logic [3:0]  strap = 4'h0, i_reg_addr = 4'h0;
   logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata, o_fetch_addr, o_step_count_param;
   logic [2:0]  o_boot_mode, o_copy_mode, seen;
   logic [15:0] src_page, dst_page, dst_x;
   logic        pll_en, clkgen;
   logic o_lock_range, o_sys_clk_en, o_core_run, o_reboot_done, o_copy_req, i_copy_done;
   int n_fail = 0, comparisons = 0, cyc = 0, k;
   always #12.5 i_clock = ~i_clock;
   // short lock count keeps each boot brief
   bss_boot_standby #(.PLL_LOCK_CYCLES(20)) dut (.i_clock, .i_reset_n,
      .i_boot_strap_bit0(strap[0]), .i_boot_strap_bit1(strap[1]),
      .i_boot_strap_bit2(strap[2]), .i_lock_range_strap(strap[3]),
      .i_sleep_release_pin, .i_halt_instr, .i_stop_instr, .i_irq, .i_copy_done,
      .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_boot_mode,
      .o_lock_range, .o_pll_enable(pll_en), .o_pll_select(), .o_clkgen_run(clkgen), .o_sys_clk_en,
      .o_sys_tick(), .o_clock_output_pin(), .o_core_run, .o_fetch_start(), .o_fetch_addr,
      .o_reboot_done, .o_copy_req, .o_copy_mode, .o_step_count_param,
      .o_source_page_param(src_page), .o_dest_page_param(dst_page),
      .o_dest_addr_pointer_x(dst_x),
      .o_dest_addr_pointer_y(), .o_src_addr_pointer_x(), .o_src_addr_pointer_y());
   bss_copy_partner u_copy (.i_clock, .i_copy_req(o_copy_req), .i_copy_mode(o_copy_mode),
      .i_slow(slow), .o_copy_done(i_copy_done), .o_seen_mode(seen));
   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task test_done;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one-cycle strobes, data read in the cycle after the read strobe
   task reg_io(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock) {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, ~w, a, d};
      @(posedge i_clock) {i_reg_wr, i_reg_rd} <= 2'b00;
      #1;
   endtask
   // bounded wait for a level or pulse; k holds the cycles taken
   task wait_for(input int which);
      for (k = 0; k < 200 && (which ? o_reboot_done : o_core_run) !== 1'b1; k++) begin
         @(posedge i_clock);
         #1;
      end
      // a wait that runs out is a failure of its own
      if (k == 200) n_fail++;
   endtask
   task pulse(input int which);
      @(posedge i_clock) {i_halt_instr, i_stop_instr, i_irq} <= 3'b001 << which;
      @(posedge i_clock) {i_halt_instr, i_stop_instr, i_irq} <= 3'b000;
      #1;
   endtask
   // hang guard: whole run needs well under a thousand cycles
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   initial begin
      // every strap code, reserved one included, lock range strap alternating from code to code
      for (int m = 0; m < 8; m++) begin
         @(posedge i_clock) {i_reset_n, strap} <= {1'b0, ~m[0], m[2:0]};
         repeat (16) @(posedge i_clock);
         i_reset_n <= 1'b1;
         wait_for(0);
         chk("boot_mode", 16'(o_boot_mode), (m == 7) ? 16'h0000 : 16'(m));
         chk("lock_range", 16'(o_lock_range), {15'h0000, ~m[0]});
         chk("pll_on", 16'(pll_en), (m == 0 || m == 4 || m == 7) ? 16'h0000 : 16'h0001);
         chk("fetch_addr", o_fetch_addr, 16'h0200);
         if (m > 0 && m < 7) chk("copy_mode", 16'(seen), 16'(m));
      end
      reg_io(1'b0, 4'h0, 16'h0000);
      chk("clkctl", o_reg_rdata, 16'h0008);
      reg_io(1'b1, 4'h2, 16'h0123);
      reg_io(1'b0, 4'h2, 16'h0000);
      chk("steps", o_reg_rdata, 16'h0123);
      chk("step_out", o_step_count_param, 16'h0123);
      reg_io(1'b0, 4'ha, 16'h0000);
      chk("unmapped", o_reg_rdata, 16'h0000);
      // every reboot entry, alternating quick and slow copy answers
      for (int n = 1; n < 7; n++) begin
         slow <= n[0];
         reg_io(1'b1, 4'h4, 16'h0080);
         reg_io(1'b1, 4'h3, (n == 6) ? 16'h0ec0 : 16'h0000);
         reg_io(1'b1, 4'h5, (n > 4) ? 16'h8000 : 16'h0000);
         reg_io(1'b1, 4'h9, 16'(n));
         wait_for(1);
         chk("reboot_mode", 16'(seen), 16'(n));
         chk("src_page", src_page, (n == 6) ? 16'h0ec0 : 16'h0000);
         chk("dst_page", dst_page, 16'h0080);
         chk("dst_x", dst_x, (n > 4) ? 16'h8000 : 16'h0000);
      end
      // external clock source and PLL off before standby
      reg_io(1'b1, 4'h0, 16'h0008);
      pulse(2);
      repeat (5) @(posedge i_clock);
      #1 chk("halted", 16'(o_core_run), 16'h0000);
      pulse(0);
      wait_for(0);
      // k counts from the edge that took the interrupt, one after it was raised
      chk("halt_wake", 16'(k + 1), 16'h000a);
      pulse(1);
      @(posedge i_clock);
      #1 chk("stopped", 16'(o_sys_clk_en), 16'h0000);
      chk("clkgen_off", 16'(clkgen), 16'h0000);
      @(posedge i_clock) i_sleep_release_pin <= 1'b1;
      wait_for(0);
      chk("stop_wake", 16'(o_core_run), 16'h0001);
      // the clock enable flop follows the state one cycle later
      @(posedge i_clock);
      #1 chk("clk_back", 16'(o_sys_clk_en), 16'h0001);
      // reset on return from standby: no-boot straps leave instruction RAM alone
      @(posedge i_clock) {i_reset_n, strap} <= 5'h00;
      repeat (16) @(posedge i_clock);
      i_reset_n <= 1'b1;
      wait_for(0);
      chk("standby_boot", 16'(o_copy_req), 16'h0000);
      test_done;
   end
endmodule // bss_boot_standby_tb_top
